/* dv/pll_status_indicator_logic_tb_top.sv */
// testbench for the status register bank
// serial host in the bench, board monitor on the pins
`default_nettype none

module pll_status_indicator_logic_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk = 1'b0;
  logic i_arst_n = 1'b0;
  logic sclk = 1'b0;
  logic cs_n = 1'b1;
  logic sdi = 1'b0;
  logic sdo;
  logic oe;
  plsi_pkg::plsi_status_s st = '0;
  plsi_pkg::plsi_pins_s pins;
  plsi_pkg::plsi_pins_s seen;
  logic [7:0] c83 = 8'h00;
  logic [7:0] c84 = 8'h00;
  logic [7:0] c85 = 8'h00;
  logic [7:0] exp_q[$];
  logic [7:0] sh;
  int nb = 0;
  int n_errors = 0;
  int checked = 0;
  int cyc = 0;

  always #25 i_clk = ~i_clk;

  plsi_status_regs i_dut (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_spi_sclk(sclk), .i_spi_cs_n(cs_n),
    .i_spi_sdi(sdi), .o_spi_sdo(sdo), .o_spi_sdo_oe(oe), .i_status(st), .o_pins(pins));
  plsi_board_mon i_mon (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_pins(pins), .o_seen(seen));

  // -------------------------------------------------------------------
  // checking
  // -------------------------------------------------------------------
  task automatic chk(input string what, input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wrap_up();
    $display("checked %0d n_errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  function automatic logic [7:0] exp_reg(input logic [14:0] a);
    case (a)
      15'h0080: return {2'h0, st.cal_second, st.cal_first, 1'h0, st.lock};
      15'h0081: return {4'h0, st.loss_third, st.loss_second, st.loss_ref_b, st.loss_ref_a};
      15'h0082: return {5'h0, st.freerun, st.holdover, st.active_ref_b};
      15'h0083: return c83 & plsi_pkg::LOCK_CTRL_MASK;
      15'h0084: return c84 & plsi_pkg::LOSS_CTRL_MASK;
      15'h0085: return c85 & plsi_pkg::OUT_CTRL_MASK;
      default: return 8'h00;
    endcase
  endfunction

  function automatic plsi_pkg::plsi_pins_s exp_pins();
    logic [4:0] v;
    plsi_pkg::plsi_pins_s p;
    v = {st.loss_third, st.loss_second, st.active_ref_b ? st.loss_ref_b : st.loss_ref_a, st.loss_ref_b, st.loss_ref_a};
    p.lock_level = st.lock ^ {c83[4], c83[2], c83[0]};
    p.lock_3v3 = {c83[5], c83[3], c83[1]};
    p.loss_level = (|(v & c84[4:0])) ^ c84[5];
    p.loss_3v3 = c84[6];
    p.out_ind_en = |c85[4:0];
    p.out_ind_level = (|(v & c85[4:0])) ^ c85[5];
    p.out_ind_3v3 = c85[6];
    return p;
  endfunction

  // read data arrives msb first; sampled at sclk rise as the host does
  always @(posedge sclk) begin
    if (oe === 1'b1) begin
      sh = {sh[6:0], sdo};
      nb++;
      if (nb == 8) begin
        nb = 0;
        if (exp_q.size() == 0) chk("unexpected read", 16'h0001, 16'h0000);
        else chk("read data", {8'h00, sh}, {8'h00, exp_q.pop_front()});
      end
    end
  end

  always @(posedge cs_n) nb = 0;

  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 60000) begin
      n_errors++;
      wrap_up();
    end
  end

  // -------------------------------------------------------------------
  // serial host and stimulus
  // -------------------------------------------------------------------
  task automatic frame(input logic rw, input logic [14:0] a, input logic [7:0] d);
    logic [23:0] w;
    w = {rw, a, d};
    @(negedge i_clk) cs_n = 1'b0;
    for (int b = 23; b >= 0; b--) begin
      sdi = w[b];
      repeat (6) @(negedge i_clk);
      sclk = 1'b1;
      repeat (6) @(negedge i_clk);
      sclk = 1'b0;
    end
    repeat (8) @(negedge i_clk);
    cs_n = 1'b1;
    repeat (12) @(negedge i_clk);
  endtask

  task automatic pin_check();
    repeat (4) begin
      st = plsi_pkg::plsi_status_s'($urandom);
      repeat (2) @(negedge i_clk);
      chk("pins", {4'h0, seen}, {4'h0, exp_pins()});
    end
  endtask

  initial begin
    void'($urandom(22701));
    repeat (6) @(negedge i_clk);
    i_arst_n = 1'b1;
    repeat (3) @(negedge i_clk);
    pin_check();
    for (int i = 0; i < 6; i++) begin
      c83 = 8'($urandom);
      c84 = 8'($urandom);
      c85 = (i == 0) ? {3'($urandom), 5'h00} : 8'($urandom);
      st = plsi_pkg::plsi_status_s'($urandom);
      frame(1'b0, 15'h0083, c83);
      frame(1'b0, 15'h0084, c84);
      frame(1'b0, 15'h0085, c85);
      frame(1'b0, 15'h0080 + 15'(i % 3), 8'hff);
      for (int a = 15'h0080; a <= 15'h0086; a++) begin
        exp_q.push_back(exp_reg(15'(a)));
        frame(1'b1, 15'(a), 8'h00);
      end
      pin_check();
    end
    // a read that never drove sdo_oe would otherwise slip through unchecked
    chk("pending reads", 16'(exp_q.size()), 16'h0000);
    wrap_up();
  end
endmodule

`default_nettype wire

/* dv/plsi_board_mon.sv */
// board logic that samples the indicator pins
// assumes pins are static levels on the port clock
`default_nettype none

module plsi_board_mon (
  input wire logic i_clk, // board clock
  input wire logic i_arst_n, // reset
  input wire plsi_pkg::plsi_pins_s i_pins, // pins
  output plsi_pkg::plsi_pins_s o_seen // sampled
);
  timeunit 1ns;
  timeprecision 1ps;
  // one flop, as a board input register would see it
  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_seen <= '0;
    end else begin
      o_seen <= i_pins;
    end
  end
endmodule

`default_nettype wire

/* dv/plsi_status_regs_chk.sv */
// assertions on the status register bank ports
// bound into plsi_status_regs; sees only its ports
`default_nettype none

module plsi_status_regs_chk (
  input wire logic i_clk, // port clock
  input wire logic i_arst_n, // reset
  input wire logic i_spi_sclk, // serial clock
  input wire logic i_spi_cs_n, // select
  input wire logic i_spi_sdi, // data in
  input wire logic o_spi_sdo, // data out
  input wire logic o_spi_sdo_oe, // out enable
  input wire plsi_pkg::plsi_status_s i_status, // status
  input wire plsi_pkg::plsi_pins_s o_pins // pins
);
  timeunit 1ns;
  timeprecision 1ps;
  // -------------------------------------------------------------------
  // helpers
  // -------------------------------------------------------------------
  logic [3:0] idle_q;
  logic [1:0] up_q;
  logic nowr_q;
  logic idle;
  logic up;
  // control only moves inside frames; settle 10 cycles after deselect
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      idle_q <= 4'h0;
      up_q <= 2'h0;
      nowr_q <= 1'b1;
    end else begin
      idle_q <= i_spi_cs_n ? idle_q + {3'h0, idle_q != 4'hf} : 4'h0;
      up_q <= up_q + {1'b0, up_q != 2'h3};
      nowr_q <= nowr_q & i_spi_cs_n;
    end
  end
  assign idle = idle_q >= 4'ha;
  assign up = up_q >= 2'h2;
  // -------------------------------------------------------------------
  // properties
  // -------------------------------------------------------------------
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  AST_LOCK_XOR: assert property (idle |-> (o_pins.lock_level ^ $past(i_status.lock)) ==
    ($past(o_pins.lock_level) ^ $past(i_status.lock, 2))) else $error("lock pin not status xor invert");
  AST_LOCK_DRV: assert property (idle |-> $stable(o_pins.lock_3v3))
    else $error("lock drive moved while idle");
  AST_LOSS_DRV: assert property (idle |-> $stable(o_pins.loss_3v3))
    else $error("loss drive moved while idle");
  AST_OUT_CTRL: assert property (idle |-> $stable({o_pins.out_ind_en, o_pins.out_ind_3v3}))
    else $error("clock output mode moved while idle");
  AST_PINS_QUIET: assert property (idle && $past(i_status) == $past(i_status, 2) |-> $stable(o_pins))
    else $error("pins moved without cause");
  AST_RST_LOCK: assert property (up && nowr_q |-> o_pins.lock_level == $past(i_status.lock))
    else $error("lock pin wrong with reset control");
  AST_RST_DRV: assert property (nowr_q |-> !o_pins.loss_3v3 && !o_pins.out_ind_3v3 && o_pins.lock_3v3 == 3'h0)
    else $error("drive mode not low after reset");
  AST_RST_LOSS: assert property (nowr_q |-> !o_pins.loss_level && !o_pins.out_ind_en && !o_pins.out_ind_level)
    else $error("loss indication active after reset");
  cover property (o_pins.out_ind_en);
  cover property ($rose(o_spi_sdo_oe));
  cover property (idle && o_pins.loss_level);
endmodule

bind plsi_status_regs plsi_status_regs_chk i_chk (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_spi_sclk(i_spi_sclk),
  .i_spi_cs_n(i_spi_cs_n), .i_spi_sdi(i_spi_sdi), .o_spi_sdo(o_spi_sdo), .o_spi_sdo_oe(o_spi_sdo_oe),
  .i_status(i_status), .o_pins(o_pins));

`default_nettype wire

/* hw/plsi_pkg.sv */
// constants and carrier types for the pll status / indicator register bank
// assumes a serial control port framed as 1 r/w bit, 15 address bits, 8 data bits
//
// Functional notes
// RULE1 - status registers calibration_and_lock_status to first_loop_state_status ignore writes
// RULE2 - d5 of calibration_and_lock_status shows second loop calibrating
// RULE3 - d4 of calibration_and_lock_status shows first loop calibrating
// RULE4 - d2..d0 of calibration_and_lock_status mirror loop lock detectors
// RULE5 - reference_loss_status d3..d0 report reference loss flags
// RULE6 - third loop loss flag from first cascade only
// RULE7 - first_loop_state_status d2 freerun, d1 holdover, first loop
// RULE8 - first_loop_state_status d0 first loop active reference b
// RULE9 - lock_pin_control d4,d2,d0 invert lock pins
// RULE10 - lock_pin_control d5,d3,d1 pick lock pin voltage
// RULE11 - loss_pin_control d5 inverts reference loss pin
// RULE12 - loss_pin_control d6 picks reference loss pin voltage
// RULE13 - loss pin ors enabled detectors d4..d0
// RULE14 - clock_output_loss_indication_control d4..d0 select detectors onto clock output
// RULE15 - all zero selects keep normal clock output
// RULE16 - enable order: third, second, active, b, a
// RULE17 - clock_output_loss_indication_control d5 inverts clock output indication level
// RULE18 - reserved bits read zero, ignore writes
// RULE19 - pin level is status xor invert bit
`default_nettype none

package plsi_pkg;

  // -------------------------------------------------------------------
  // serial frame
  // -------------------------------------------------------------------
  localparam int ADDR_W = 15;
  localparam int DATA_W = 8;
  localparam int CNT_W = 5;
  localparam logic [CNT_W-1:0] INSTR_LAST = 5'h0f;
  localparam logic [CNT_W-1:0] FRAME_LAST = 5'h17;
  localparam logic [CNT_W-1:0] FRAME_DONE = 5'h18;
  localparam int INSTR_RW_BIT = 15;
  localparam int FRAME_RW_BIT = 23;

  // -------------------------------------------------------------------
  // register map
  // -------------------------------------------------------------------
  localparam logic [ADDR_W-1:0] ADDR_CAL_LOCK_STATUS = 15'h0080;
  localparam logic [ADDR_W-1:0] ADDR_REF_LOSS_STATUS = 15'h0081;
  localparam logic [ADDR_W-1:0] ADDR_LOOP_STATE_STATUS = 15'h0082;
  localparam logic [ADDR_W-1:0] ADDR_LOCK_PIN_CTRL = 15'h0083;
  localparam logic [ADDR_W-1:0] ADDR_LOSS_PIN_CTRL = 15'h0084;
  localparam logic [ADDR_W-1:0] ADDR_OUT_LOSS_CTRL = 15'h0085;

  localparam logic [DATA_W-1:0] CTRL_RESET = 8'h00;
  localparam logic [DATA_W-1:0] LOCK_CTRL_MASK = 8'h3f;
  localparam logic [DATA_W-1:0] LOSS_CTRL_MASK = 8'h7f;
  localparam logic [DATA_W-1:0] OUT_CTRL_MASK = 8'h7f;

  // field positions
  localparam int CAL_SECOND_BIT = 5;
  localparam int CAL_FIRST_BIT = 4;
  localparam int FREERUN_BIT = 2;
  localparam int HOLDOVER_BIT = 1;
  localparam int ACTIVE_REF_BIT = 0;
  localparam int LOCK_INV_BIT0 = 0;
  localparam int LOCK_3V3_BIT0 = 1;
  localparam int LOCK_FIELD_STEP = 2;
  localparam int LOSS_SEL_W = 5;
  localparam int LOSS_INV_BIT = 5;
  localparam int LOSS_3V3_BIT = 6;

  // -------------------------------------------------------------------
  // carriers
  // -------------------------------------------------------------------
  typedef struct packed {
    logic cal_second;
    logic cal_first;
    logic [2:0] lock;         // third, second, first
    logic loss_third;         // first cascade stage only
    logic loss_second;
    logic loss_ref_b;
    logic loss_ref_a;
    logic freerun;
    logic holdover;
    logic active_ref_b;
  } plsi_status_s;

  typedef struct packed {
    logic [2:0] lock_level;
    logic [2:0] lock_3v3;
    logic loss_level;
    logic loss_3v3;
    logic out_ind_en;
    logic out_ind_level;
    logic out_ind_3v3;
  } plsi_pins_s;

endpackage

`default_nettype wire

/* hw/plsi_status_regs.sv */
// status and indicator pin control register bank for a three loop clock generator
// assumes status inputs come from logic on i_clk; serial port pins are asynchronous
`default_nettype none

module plsi_status_regs (
  input wire logic i_clk,                          // port clock, 20 mhz
  input wire logic i_arst_n,                       // power-on reset
  input wire logic i_spi_sclk,                     // serial clock pin
  input wire logic i_spi_cs_n,                     // chip select pin
  input wire logic i_spi_sdi,                      // serial data in
  output logic o_spi_sdo,                          // serial data out
  output logic o_spi_sdo_oe,                       // high while driving sdo
  input wire plsi_pkg::plsi_status_s i_status,     // live loop status
  output plsi_pkg::plsi_pins_s o_pins              // indicator pin controls
);

  // -------------------------------------------------------------------
  // state
  // -------------------------------------------------------------------
  typedef struct packed {
    logic sclk_s1;
    logic sclk_s2;
    logic sclk_s3;
    logic csn_s1;
    logic csn_s2;
    logic sdi_s1;
    logic sdi_s2;
    logic [plsi_pkg::CNT_W-1:0] bit_cnt;
    logic [plsi_pkg::FRAME_RW_BIT:0] shift;
    logic rd_active;
    logic [plsi_pkg::DATA_W-1:0] rd_shift;
    logic sdo;
    logic sdo_oe;
    logic [plsi_pkg::DATA_W-1:0] lock_ctrl;
    logic [plsi_pkg::DATA_W-1:0] loss_ctrl;
    logic [plsi_pkg::DATA_W-1:0] out_ctrl;
    plsi_pkg::plsi_pins_s pins;
  } plsi_state_s;

  plsi_state_s state_q;
  plsi_state_s state_d;

  // -------------------------------------------------------------------
  // helpers
  // -------------------------------------------------------------------
  // detector vector in enable-bit order
  function automatic logic [plsi_pkg::LOSS_SEL_W-1:0] loss_vector(
    input plsi_pkg::plsi_status_s st
  );
    logic active_lost;
    active_lost = st.active_ref_b ? st.loss_ref_b : st.loss_ref_a;
    loss_vector = {st.loss_third, st.loss_second, active_lost,     // [RULE16]
                   st.loss_ref_b, st.loss_ref_a};
  endfunction

  function automatic logic [plsi_pkg::DATA_W-1:0] reg_read(
    input logic [plsi_pkg::ADDR_W-1:0] addr,
    input plsi_pkg::plsi_status_s st,
    input plsi_state_s s
  );
    reg_read = '0;                                                 // [RULE18]
    unique case (addr)
      plsi_pkg::ADDR_CAL_LOCK_STATUS: begin
        reg_read[plsi_pkg::CAL_SECOND_BIT] = st.cal_second;        // [RULE2]
        reg_read[plsi_pkg::CAL_FIRST_BIT] = st.cal_first;          // [RULE3]
        reg_read[2:0] = st.lock;                                   // [RULE4]
      end
      plsi_pkg::ADDR_REF_LOSS_STATUS: begin
        // third loop flag already comes from the first cascade stage
        reg_read[3:0] = {st.loss_third, st.loss_second,            // [RULE5] [RULE6]
                         st.loss_ref_b, st.loss_ref_a};
      end
      plsi_pkg::ADDR_LOOP_STATE_STATUS: begin
        reg_read[plsi_pkg::FREERUN_BIT] = st.freerun;              // [RULE7]
        reg_read[plsi_pkg::HOLDOVER_BIT] = st.holdover;            // [RULE7]
        reg_read[plsi_pkg::ACTIVE_REF_BIT] = st.active_ref_b;      // [RULE8]
      end
      plsi_pkg::ADDR_LOCK_PIN_CTRL: begin
        reg_read = s.lock_ctrl;
      end
      plsi_pkg::ADDR_LOSS_PIN_CTRL: begin
        reg_read = s.loss_ctrl;
      end
      plsi_pkg::ADDR_OUT_LOSS_CTRL: begin
        reg_read = s.out_ctrl;
      end
      default: begin
        reg_read = '0;
      end
    endcase
  endfunction

  // -------------------------------------------------------------------
  // next state
  // -------------------------------------------------------------------
  always_comb begin
    logic rise;
    logic fall;
    logic [plsi_pkg::FRAME_RW_BIT:0] nshift;
    logic [plsi_pkg::ADDR_W-1:0] waddr;
    logic [plsi_pkg::DATA_W-1:0] wdata;
    logic [plsi_pkg::LOSS_SEL_W-1:0] lost;
    logic [plsi_pkg::LOSS_SEL_W-1:0] out_sel;
    logic [plsi_pkg::LOSS_SEL_W-1:0] pin_sel;
    rise = 1'b0;
    fall = 1'b0;
    nshift = '0;
    waddr = '0;
    wdata = '0;
    lost = '0;
    out_sel = '0;
    pin_sel = '0;
    state_d = state_q;

    // synchronisers; the second stage feeds logic, and sclk_s3 also feeds the sclk edge detect
    state_d.sclk_s1 = i_spi_sclk;
    state_d.sclk_s2 = state_q.sclk_s1;
    state_d.sclk_s3 = state_q.sclk_s2;
    state_d.csn_s1 = i_spi_cs_n;
    state_d.csn_s2 = state_q.csn_s1;
    state_d.sdi_s1 = i_spi_sdi;
    state_d.sdi_s2 = state_q.sdi_s1;

    rise = state_q.sclk_s2 & ~state_q.sclk_s3;
    fall = ~state_q.sclk_s2 & state_q.sclk_s3;
    nshift = {state_q.shift[plsi_pkg::FRAME_RW_BIT-1:0], state_q.sdi_s2};

    if (state_q.csn_s2) begin
      // deselect aborts any partial frame
      state_d.bit_cnt = '0;
      state_d.rd_active = 1'b0;
      state_d.sdo_oe = 1'b0;
      state_d.sdo = 1'b0;
    end else begin
      if (rise && state_q.bit_cnt != plsi_pkg::FRAME_DONE) begin
        state_d.shift = nshift;
        state_d.bit_cnt = state_q.bit_cnt + 1'b1;
        if (state_q.bit_cnt == plsi_pkg::INSTR_LAST && nshift[plsi_pkg::INSTR_RW_BIT]) begin
          state_d.rd_active = 1'b1;
          state_d.rd_shift = reg_read(nshift[plsi_pkg::ADDR_W-1:0], i_status, state_q);
        end
        if (state_q.bit_cnt == plsi_pkg::FRAME_LAST && !nshift[plsi_pkg::FRAME_RW_BIT]) begin
          waddr = nshift[plsi_pkg::FRAME_RW_BIT-1:plsi_pkg::DATA_W];
          wdata = nshift[plsi_pkg::DATA_W-1:0];
          // status addresses fall through: writes there have no effect
          unique case (waddr)                                        // [RULE1]
            plsi_pkg::ADDR_LOCK_PIN_CTRL: begin
              state_d.lock_ctrl = wdata & plsi_pkg::LOCK_CTRL_MASK;  // [RULE18]
            end
            plsi_pkg::ADDR_LOSS_PIN_CTRL: begin
              state_d.loss_ctrl = wdata & plsi_pkg::LOSS_CTRL_MASK;  // [RULE18]
            end
            plsi_pkg::ADDR_OUT_LOSS_CTRL: begin
              state_d.out_ctrl = wdata & plsi_pkg::OUT_CTRL_MASK;    // [RULE18]
            end
            default: begin
              state_d.lock_ctrl = state_q.lock_ctrl;
            end
          endcase
        end
      end
      // read data leaves on falling edges, msb first
      if (fall && state_q.rd_active) begin
        state_d.sdo = state_q.rd_shift[plsi_pkg::DATA_W-1];
        state_d.sdo_oe = 1'b1;
        state_d.rd_shift = {state_q.rd_shift[plsi_pkg::DATA_W-2:0], 1'b0};
      end
    end

    // -----------------------------------------------------------------
    // indicator pins
    // -----------------------------------------------------------------
    // one cycle of register delay buys glitch-free pins from flops
    for (int i = 0; i < 3; i++) begin
      state_d.pins.lock_level[i] = i_status.lock[i]                  // [RULE19]
        ^ state_q.lock_ctrl[plsi_pkg::LOCK_INV_BIT0 + plsi_pkg::LOCK_FIELD_STEP * i]; // [RULE9]
      state_d.pins.lock_3v3[i] =
        state_q.lock_ctrl[plsi_pkg::LOCK_3V3_BIT0 + plsi_pkg::LOCK_FIELD_STEP * i];   // [RULE10]
    end

    lost = loss_vector(i_status);
    pin_sel = state_q.loss_ctrl[plsi_pkg::LOSS_SEL_W-1:0];
    out_sel = state_q.out_ctrl[plsi_pkg::LOSS_SEL_W-1:0];

    state_d.pins.loss_level = (|(lost & pin_sel))                    // [RULE13]
      ^ state_q.loss_ctrl[plsi_pkg::LOSS_INV_BIT];                   // [RULE11] [RULE19]
    state_d.pins.loss_3v3 = state_q.loss_ctrl[plsi_pkg::LOSS_3V3_BIT]; // [RULE12]

    // zero select hands the output back to the loop's own clock
    state_d.pins.out_ind_en = |out_sel;                              // [RULE15]
    state_d.pins.out_ind_level = (|(lost & out_sel))                 // [RULE14]
      ^ state_q.out_ctrl[plsi_pkg::LOSS_INV_BIT];                    // [RULE17] [RULE19]
    state_d.pins.out_ind_3v3 = state_q.out_ctrl[plsi_pkg::LOSS_3V3_BIT];
  end

  // -------------------------------------------------------------------
  // registers
  // -------------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_q <= '0;
      state_q.csn_s1 <= 1'b1;
      state_q.csn_s2 <= 1'b1;
      state_q.lock_ctrl <= plsi_pkg::CTRL_RESET;
      state_q.loss_ctrl <= plsi_pkg::CTRL_RESET;
      state_q.out_ctrl <= plsi_pkg::CTRL_RESET;
    end else begin
      state_q <= state_d;
    end
  end

  // -------------------------------------------------------------------
  // outputs
  // -------------------------------------------------------------------
  assign o_spi_sdo = state_q.sdo;
  assign o_spi_sdo_oe = state_q.sdo_oe;
  assign o_pins = state_q.pins;

endmodule

`default_nettype wire
